// ===== verilog/wrm_formatter.sv
// Weld report message formatter: waveform capture and host text messages
`timescale 1ns/10ps
`default_nettype none

module wrm_formatter import wrm_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic weld_active,
   input wire logic [15:0] cur_amps,
   input wire logic [15:0] volt_mv,
   input wire wrm_op_t op_state,
   input wire logic state_read_req,
   input wire logic counters_read_req,
   input wire logic alarm_read_req,
   input wire logic alarm_event,
   input wire logic [WRM_TXT_MAX*8-1:0] alarm_text,
   input wire logic [5:0] alarm_len,
   input wire logic [31:0] cnt_total,
   input wire logic [31:0] cnt_high,
   input wire logic [31:0] cnt_low,
   input wire logic [31:0] cnt_good,
   input wire logic current_read_req,
   input wire logic voltage_read_req,
   input wire logic power_read_req,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic busy
);
   typedef struct packed {
      wrm_st_t st;
      wrm_msg_t msg;
      logic [3:0] ph;
      wrm_sid_t sid;
      logic [5:0] pos;
      logic [31:0] num;
      logic [3:0] pidx;
      logic [3:0] dig;
      logic started;
      logic [10:0] idx;
      logic [10:0] cnt;
      logic [WRM_NUM_MSG-1:0] pend;
      wrm_op_t op_prev;
      logic [8:0] tick;
      logic [10:0] wr;
      logic [10:0] last_cnt;
      logic weld_prev;
      logic [7:0] last_byte;
   } wrm_state_t;

   localparam logic [8:0] TICK_LAST = 9'(WRM_SAMPLE_CYC - 1);

   wrm_state_t s_r, s_nxt;
   wrm_act_t act;
   wrm_sid_t arg_sid;
   wrm_nsel_t arg_ns;
   logic [15:0] cur_mem [WRM_MEM_DEPTH];
   logic [15:0] volt_mem [WRM_MEM_DEPTH];
   logic [31:0] pow_mem [WRM_MEM_DEPTH];
   logic [15:0] cur_rd, volt_rd;
   logic [31:0] pow_rd, prod, pow_w, numsel, pw;
   logic wr_en, weld_rise, push, fifo_ready;
   logic [7:0] byte_out;
   logic [WRM_NUM_MSG-1:0] pend_set, pend_clr;
   logic [63:0] str_bits;
   logic [5:0] str_len;

   // Message programs: one action per step position
   always_comb begin
      act = WRM_A_END;
      arg_sid = WRM_T_LF;
      arg_ns = WRM_NS_COUNT;
      case (s_r.msg)
         WRM_M_STATE, WRM_M_ALARM: begin
            case (s_r.ph)
               4'h0: begin
                  act = WRM_A_STR;
                  arg_sid = (s_r.msg == WRM_M_STATE) ? WRM_K_STATE : WRM_K_ALARM;
               end
               4'h1: begin
                  if (s_r.msg == WRM_M_ALARM) begin
                     act = WRM_A_TXT;
                  end else begin
                     act = WRM_A_STR;
                     arg_sid = (op_state == WRM_OP_RUN) ? WRM_N_RUN :
                               (op_state == WRM_OP_MENU) ? WRM_N_MENU : WRM_N_MONITOR;
                  end
               end
               4'h2: begin
                  act = WRM_A_STR;
                  arg_sid = WRM_T_CRLF;
               end
               4'h3: begin
                  act = WRM_A_STR;
                  arg_sid = WRM_T_LF;
               end
               default: act = WRM_A_END;
            endcase
         end
         WRM_M_COUNTERS: begin
            act = WRM_A_STR;
            case (s_r.ph)
               4'h0: arg_sid = WRM_K_COUNTERS;
               4'h2: arg_sid = WRM_K_TOTAL;
               4'h5: arg_sid = WRM_K_HIGH;
               4'h8: arg_sid = WRM_K_LOW;
               4'hB: arg_sid = WRM_K_GOOD;
               4'h3, 4'h6, 4'h9, 4'hC: begin
                  act = WRM_A_NUM;
                  arg_ns = wrm_nsel_t'(3'((s_r.ph - 4'h3) / 4'h3));
               end
               4'hE: arg_sid = WRM_T_LF;
               4'hF: act = WRM_A_END;
               default: arg_sid = WRM_T_CRLF;
            endcase
         end
         default: begin
            case (s_r.ph)
               4'h0: begin
                  act = WRM_A_STR;
                  arg_sid = (s_r.msg == WRM_M_CURRENT) ? WRM_K_CURRENT :
                            (s_r.msg == WRM_M_VOLTAGE) ? WRM_K_VOLTAGE : WRM_K_POWER;
               end
               4'h1: act = WRM_A_NUM;
               4'h2, 4'h4: begin
                  act = WRM_A_STR;
                  arg_sid = WRM_T_CRLF;
               end
               WRM_PH_WAVE_SAMP: act = WRM_A_SAMP;
               4'h5: act = WRM_A_LOOP;
               WRM_PH_WAVE_LF: begin
                  act = WRM_A_STR;
                  arg_sid = WRM_T_LF;
               end
               default: act = WRM_A_END;
            endcase
         end
      endcase
   end

   always_comb begin
      prod = 32'(cur_amps) * 32'(volt_mv);
      pow_w = prod / WRM_MW_PER_W;
      weld_rise = weld_active && !s_r.weld_prev;
      wr_en = weld_active && !weld_rise && (s_r.tick == TICK_LAST)
              && (s_r.wr < WRM_MAX_SAMPLES);
      case (arg_ns)
         WRM_NS_TOTAL: numsel = cnt_total;
         WRM_NS_HIGH: numsel = cnt_high;
         WRM_NS_LOW: numsel = cnt_low;
         WRM_NS_GOOD: numsel = cnt_good;
         default: numsel = 32'(s_r.cnt);
      endcase
      str_bits = wrm_str_bits(s_r.sid);
      str_len = wrm_str_len(s_r.sid);
      pw = WRM_POW10[s_r.pidx];
   end

   always_comb begin
      s_nxt = s_r;
      push = 1'b0;
      byte_out = WRM_ASCII_LF;
      pend_clr = '0;
      pend_set = '0;
      pend_set[WRM_M_STATE] = state_read_req || (op_state != s_r.op_prev);
      pend_set[WRM_M_COUNTERS] = counters_read_req;
      pend_set[WRM_M_ALARM] = alarm_read_req || alarm_event;
      pend_set[WRM_M_CURRENT] = current_read_req;
      pend_set[WRM_M_VOLTAGE] = voltage_read_req;
      pend_set[WRM_M_POWER] = power_read_req;
      s_nxt.op_prev = op_state;

      // Sampling runs only while the weld is on; the count freezes at weld end
      s_nxt.weld_prev = weld_active;
      if (weld_rise) begin
         s_nxt.tick = '0;
         s_nxt.wr = '0;
      end else if (weld_active) begin
         s_nxt.tick = (s_r.tick == TICK_LAST) ? 9'h000 : s_r.tick + 9'h001;
         if (wr_en) begin
            s_nxt.wr = s_r.wr + 11'h001;
         end
      end else if (s_r.weld_prev) begin
         s_nxt.last_cnt = s_r.wr;
      end

      case (s_r.st)
         WRM_S_IDLE: begin
            // Lowest message index wins when several are pending
            for (int m = WRM_NUM_MSG - 1; m >= 0; m--) begin
               if (s_r.pend[m]) begin
                  s_nxt.msg = wrm_msg_t'(3'(m));
               end
            end
            if (|s_r.pend) begin
               pend_clr[s_nxt.msg] = 1'b1;
               s_nxt.ph = '0;
               s_nxt.idx = '0;
               s_nxt.cnt = s_r.last_cnt;
               s_nxt.st = WRM_S_STEP;
            end
         end
         WRM_S_STEP: begin
            s_nxt.pos = '0;
            case (act)
               WRM_A_STR: begin
                  s_nxt.sid = arg_sid;
                  s_nxt.st = WRM_S_STR;
               end
               WRM_A_NUM: begin
                  s_nxt.num = numsel;
                  s_nxt.pidx = 4'(WRM_DIGITS - 1);
                  s_nxt.dig = '0;
                  s_nxt.started = 1'b0;
                  s_nxt.st = WRM_S_NUM;
               end
               WRM_A_TXT: s_nxt.st = WRM_S_TXT;
               WRM_A_SAMP: begin
                  if (s_r.idx < s_r.cnt) begin
                     s_nxt.st = WRM_S_RD;
                  end else begin
                     s_nxt.ph = WRM_PH_WAVE_LF;
                  end
               end
               WRM_A_LOOP: begin
                  if (s_r.idx + 11'h001 < s_r.cnt) begin
                     s_nxt.idx = s_r.idx + 11'h001;
                     s_nxt.ph = WRM_PH_WAVE_SAMP;
                  end else begin
                     s_nxt.ph = s_r.ph + 4'h1;
                  end
               end
               default: s_nxt.st = WRM_S_IDLE;
            endcase
         end
         WRM_S_STR: begin
            push = 1'b1;
            byte_out = str_bits[8*(str_len - 6'h01 - s_r.pos) +: 8];
            if (fifo_ready) begin
               s_nxt.pos = s_r.pos + 6'h01;
               if (s_r.pos == str_len - 6'h01) begin
                  s_nxt.ph = s_r.ph + 4'h1;
                  s_nxt.st = WRM_S_STEP;
               end
            end
         end
         WRM_S_TXT: begin
            if (s_r.pos >= alarm_len) begin
               s_nxt.ph = s_r.ph + 4'h1;
               s_nxt.st = WRM_S_STEP;
            end else begin
               push = 1'b1;
               byte_out = alarm_text[8*s_r.pos +: 8];
               if (fifo_ready) begin
                  s_nxt.pos = s_r.pos + 6'h01;
               end
            end
         end
         WRM_S_RD: begin
            // Memory reads one cycle late, so the address settled in the step cycle
            s_nxt.num = (s_r.msg == WRM_M_CURRENT) ? 32'(cur_rd) :
                        (s_r.msg == WRM_M_VOLTAGE) ? 32'(volt_rd) : pow_rd;
            s_nxt.pidx = 4'(WRM_DIGITS - 1);
            s_nxt.dig = '0;
            s_nxt.started = 1'b0;
            s_nxt.st = WRM_S_NUM;
         end
         default: begin
            // Digits by repeated subtraction: at most nine subtractions each, no divider
            if (s_r.num >= pw) begin
               s_nxt.num = s_r.num - pw;
               s_nxt.dig = s_r.dig + 4'h1;
            end else begin
               push = s_r.started || (s_r.dig != 4'h0) || (s_r.pidx == 4'h0);
               byte_out = WRM_ASCII_ZERO + 8'(s_r.dig);
               if (fifo_ready || !push) begin
                  s_nxt.started = s_r.started || push;
                  s_nxt.dig = '0;
                  s_nxt.pidx = s_r.pidx - 4'h1;
                  if (s_r.pidx == 4'h0) begin
                     s_nxt.ph = s_r.ph + 4'h1;
                     s_nxt.st = WRM_S_STEP;
                  end
               end
            end
         end
      endcase
      if (push && fifo_ready) begin
         s_nxt.last_byte = byte_out;
      end
      s_nxt.pend = (s_r.pend & ~pend_clr) | pend_set;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         cur_mem[s_r.wr] <= cur_amps;
         volt_mem[s_r.wr] <= volt_mv;
         pow_mem[s_r.wr] <= pow_w;
      end
      cur_rd <= cur_mem[s_r.idx];
      volt_rd <= volt_mem[s_r.idx];
      pow_rd <= pow_mem[s_r.idx];
   end

   assign busy = (s_r.st != WRM_S_IDLE);

   wrm_fifo #(.W(WRM_FIFO_W), .D(WRM_FIFO_D)) u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(byte_out),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );

   // Helper: cycles since the previous sample within one weld
   logic [15:0] gap_r;
   logic gap_vld_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gap_r <= '0;
         gap_vld_r <= 1'b0;
      end else begin
         gap_r <= wr_en ? 16'h0000 : gap_r + 16'h0001;
         gap_vld_r <= weld_rise ? 1'b0 : (gap_vld_r || wr_en);
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_state_end;
      (s_r.st == WRM_S_STEP && act == WRM_A_END && s_r.msg == WRM_M_STATE)
         |-> s_r.last_byte == WRM_ASCII_LF;
   endproperty
   a_state_end: assert property (p_state_end) else $error("state message not ended by LF");

   // Checks the latched piece, so a wrong load into the sender is caught
   property p_state_name;
      (s_r.st == WRM_S_STR && s_r.msg == WRM_M_STATE && s_r.ph == 4'h1)
         |-> s_r.sid inside {WRM_N_RUN, WRM_N_MENU, WRM_N_MONITOR};
   endproperty
   a_state_name: assert property (p_state_name) else $error("bad state name");

   property p_state_change;
      (op_state != s_r.op_prev) |=> s_r.pend[WRM_M_STATE];
   endproperty
   a_state_change: assert property (p_state_change) else $error("state change not queued");

   property p_cnt_total;
      (s_r.st == WRM_S_STEP && s_r.msg == WRM_M_COUNTERS && s_r.ph == 4'h3)
         |=> s_r.st == WRM_S_NUM && s_r.num == $past(cnt_total);
   endproperty
   a_cnt_total: assert property (p_cnt_total) else $error("TOTAL value not loaded");

   property p_alarm_end;
      (s_r.st == WRM_S_STEP && act == WRM_A_END && s_r.msg == WRM_M_ALARM)
         |-> s_r.last_byte == WRM_ASCII_LF;
   endproperty
   a_alarm_end: assert property (p_alarm_end) else $error("alarm message not ended by LF");

   property p_alarm_event;
      alarm_event |=> s_r.pend[WRM_M_ALARM];
   endproperty
   a_alarm_event: assert property (p_alarm_event) else $error("alarm event not queued");

   property p_wave_end;
      (s_r.st == WRM_S_STEP && act == WRM_A_END && s_r.msg == WRM_M_CURRENT)
         |-> s_r.last_byte == WRM_ASCII_LF;
   endproperty
   a_wave_end: assert property (p_wave_end) else $error("wave message not ended by LF");

   property p_sample_gap;
      (wr_en && gap_vld_r) |-> gap_r == 16'(WRM_SAMPLE_CYC - 1);
   endproperty
   a_sample_gap: assert property (p_sample_gap) else $error("sample spacing wrong");

   property p_count_limit;
      s_r.last_cnt < 11'(WRM_SAMPLE_LIMIT) && s_r.wr < 11'(WRM_SAMPLE_LIMIT);
   endproperty
   a_count_limit: assert property (p_count_limit) else $error("sample count reached limit");

   property p_digit;
      (push && s_r.st == WRM_S_NUM)
         |-> byte_out >= WRM_ASCII_ZERO && byte_out <= WRM_ASCII_NINE;
   endproperty
   a_digit: assert property (p_digit) else $error("non-digit in number field");

   c_state_msg: cover property (s_r.st == WRM_S_STEP && act == WRM_A_END
                                && s_r.msg == WRM_M_STATE);
   c_wave_loop: cover property (s_r.st == WRM_S_STEP && act == WRM_A_LOOP
                                && s_r.idx + 11'h001 < s_r.cnt);
   c_fifo_full: cover property (push && !fifo_ready);

endmodule // wrm_formatter

`default_nettype wire

// ===== verilog/wrm_pkg.sv
// Shared constants, enumerations and text tables of the weld report formatter
package wrm_pkg;

   // Sampling and clock timing
   localparam int WRM_CLK_PERIOD_NS = 100;
   localparam int WRM_SAMPLE_US = 40;
   localparam int WRM_SAMPLE_CYC = (WRM_SAMPLE_US * 1000) / WRM_CLK_PERIOD_NS;

   // Waveform storage: the reported count always stays below the limit
   localparam int WRM_SAMPLE_LIMIT = 2000;
   localparam int WRM_MEM_DEPTH = WRM_SAMPLE_LIMIT - 1;
   localparam logic [10:0] WRM_MAX_SAMPLES = 11'h7CF;

   // Milliwatts per watt, for power from amperes times millivolts
   localparam logic [31:0] WRM_MW_PER_W = 32'h0000_03E8;

   // Decimal conversion of 32-bit values
   localparam int WRM_DIGITS = 10;
   localparam logic [31:0] WRM_POW10 [WRM_DIGITS] = '{
      32'h0000_0001, 32'h0000_000A, 32'h0000_0064, 32'h0000_03E8, 32'h0000_2710,
      32'h0001_86A0, 32'h000F_4240, 32'h0098_9680, 32'h05F5_E100, 32'h3B9A_CA00};
   localparam logic [7:0] WRM_ASCII_ZERO = 8'h30;
   localparam logic [7:0] WRM_ASCII_NINE = 8'h39;
   localparam logic [7:0] WRM_ASCII_LF = 8'h0A;

   // Alarm text: characters held on the screen, first character in the low byte
   localparam int WRM_TXT_MAX = 32;

   // Step positions inside the waveform message program
   localparam logic [3:0] WRM_PH_WAVE_SAMP = 4'h3;
   localparam logic [3:0] WRM_PH_WAVE_LF = 4'h6;

   // Output FIFO
   localparam int WRM_FIFO_W = 8;
   localparam int WRM_FIFO_D = 8;

   typedef enum logic [1:0] {WRM_OP_RUN, WRM_OP_MENU, WRM_OP_MONITOR} wrm_op_t;

   typedef enum logic [2:0] {
      WRM_M_STATE, WRM_M_COUNTERS, WRM_M_ALARM, WRM_M_CURRENT, WRM_M_VOLTAGE, WRM_M_POWER
   } wrm_msg_t;
   localparam int WRM_NUM_MSG = 6;

   typedef enum logic [2:0] {
      WRM_S_IDLE, WRM_S_STEP, WRM_S_STR, WRM_S_NUM, WRM_S_TXT, WRM_S_RD
   } wrm_st_t;

   typedef enum logic [2:0] {
      WRM_A_STR, WRM_A_NUM, WRM_A_TXT, WRM_A_SAMP, WRM_A_LOOP, WRM_A_END
   } wrm_act_t;

   typedef enum logic [2:0] {
      WRM_NS_TOTAL, WRM_NS_HIGH, WRM_NS_LOW, WRM_NS_GOOD, WRM_NS_COUNT
   } wrm_nsel_t;

   typedef enum logic [3:0] {
      WRM_K_STATE, WRM_K_COUNTERS, WRM_K_ALARM, WRM_K_CURRENT, WRM_K_VOLTAGE, WRM_K_POWER,
      WRM_K_TOTAL, WRM_K_HIGH, WRM_K_LOW, WRM_K_GOOD,
      WRM_N_RUN, WRM_N_MENU, WRM_N_MONITOR, WRM_T_CRLF, WRM_T_LF
   } wrm_sid_t;

   // Text pieces, right aligned: character k of a piece of length n sits at byte n-1-k
   function automatic logic [63:0] wrm_str_bits(input wrm_sid_t id);
      case (id)
         WRM_K_STATE: return 64'("STATE ");
         WRM_K_COUNTERS: return 64'("COUNTERS");
         WRM_K_ALARM: return 64'("ALARM ");
         WRM_K_CURRENT: return 64'("CURRENT ");
         WRM_K_VOLTAGE: return 64'("VOLTAGE ");
         WRM_K_POWER: return 64'("POWER ");
         WRM_K_TOTAL: return 64'("TOTAL ");
         WRM_K_HIGH: return 64'("HIGH ");
         WRM_K_LOW: return 64'("LOW ");
         WRM_K_GOOD: return 64'("GOOD ");
         WRM_N_RUN: return 64'("RUN");
         WRM_N_MENU: return 64'("MENU");
         WRM_N_MONITOR: return 64'("MONITOR");
         WRM_T_CRLF: return 64'h0000_0000_0000_0D0A;
         default: return 64'h0000_0000_0000_000A;
      endcase
   endfunction

   function automatic logic [5:0] wrm_str_len(input wrm_sid_t id);
      case (id)
         WRM_K_STATE, WRM_K_ALARM, WRM_K_POWER, WRM_K_TOTAL: return 6'h06;
         WRM_K_COUNTERS, WRM_K_CURRENT, WRM_K_VOLTAGE: return 6'h08;
         WRM_K_HIGH, WRM_K_GOOD, WRM_N_MENU: return 6'h04 + 6'(id == WRM_K_HIGH
                                                             || id == WRM_K_GOOD);
         WRM_K_LOW: return 6'h04;
         WRM_N_RUN: return 6'h03;
         WRM_N_MONITOR: return 6'h07;
         WRM_T_CRLF: return 6'h02;
         default: return 6'h01;
      endcase
   endfunction

endpackage

// ===== verilog/wrm_fifo.sv
// Byte FIFO between the message formatter and the serial transmitter
`timescale 1ns/10ps
`default_nettype none

module wrm_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } wrm_fifo_state_t;

   wrm_fifo_state_t s_r, s_nxt;
   logic [W-1:0] mem [D];
   logic full, empty, push, pop;

   always_comb begin
      empty = (s_r.wp == s_r.rp);
      full = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && (s_r.wp[AW] != s_r.rp[AW]);
      in_ready = !full;
      out_valid = !empty;
      out_data = mem[s_r.rp[AW-1:0]];
      push = in_valid && !full;
      pop = out_ready && !empty;
      s_nxt = s_r;
      if (push) begin
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Storage needs no reset: empty pointers hide stale words
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[s_r.wp[AW-1:0]] <= in_data;
      end
   end

endmodule // wrm_fifo

`default_nettype wire

// ===== tb/wrm_host_model.sv
// Host-side model of the serial text link: takes message bytes, may stall
`timescale 1ns/10ps
`default_nettype none

module wrm_host_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic slow,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic got,
   output logic [7:0] got_byte
);
   // Slow mode refuses every other cycle so the FIFO fills and drains
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tx_ready <= 1'b0;
         got <= 1'b0;
         got_byte <= 8'h00;
      end else begin
         tx_ready <= slow ? ~tx_ready : 1'b1;
         got <= tx_valid && tx_ready;
         got_byte <= tx_data;
      end
   end
endmodule // wrm_host_model

`default_nettype wire

// ===== tb/wrm_formatter_test.sv
// Self-checking bench of the weld report message formatter
`timescale 1ns/10ps
`default_nettype none

module wrm_formatter_test import wrm_pkg::*; ;
   localparam string CRLF = "\015\012";
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic weld_active = 1'b0;
   logic slow = 1'b0;
   logic [15:0] cur_amps = 16'h0000;
   logic [15:0] volt_mv = 16'h0000;
   wrm_op_t op_state = WRM_OP_RUN;
   logic [6:0] req = 7'h00;
   logic [WRM_TXT_MAX*8-1:0] alarm_text = '0;
   logic [5:0] alarm_len = 6'h00;
   logic [31:0] cnt_total = 32'h0000_0000;
   logic [31:0] cnt_high = 32'h0000_0000;
   logic [31:0] cnt_low = 32'h0000_0000;
   logic [31:0] cnt_good = 32'h0000_0000;
   logic [7:0] tx_data;
   logic [7:0] got_byte;
   logic tx_valid;
   logic tx_ready;
   logic busy;
   logic got;
   int fails = 0;
   int num_checks = 0;

   always #50 sys_clk = ~sys_clk;

   wrm_formatter i_wrm_formatter (.sys_clk(sys_clk), .rstn(rstn), .weld_active(weld_active),
      .cur_amps(cur_amps), .volt_mv(volt_mv), .op_state(op_state), .state_read_req(req[0]),
      .counters_read_req(req[1]), .alarm_read_req(req[2]), .alarm_event(req[3]),
      .alarm_text(alarm_text), .alarm_len(alarm_len), .cnt_total(cnt_total),
      .cnt_high(cnt_high), .cnt_low(cnt_low), .cnt_good(cnt_good),
      .current_read_req(req[4]), .voltage_read_req(req[5]), .power_read_req(req[6]),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy));

   wrm_host_model i_wrm_host_model (.sys_clk(sys_clk), .rstn(rstn), .slow(slow),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .got(got),
      .got_byte(got_byte));

   task automatic pulse(input logic [6:0] m);
      @(negedge sys_clk) req = m;
      @(negedge sys_clk) req = 7'h00;
   endtask

   task automatic check_bit(input string what, input logic exp, input logic seen);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %b seen %b", what, exp, seen);
      end
   endtask

   // Each accepted byte shows on got for exactly one cycle
   task automatic expect_msg(input string what, input string exp);
      int wait_cyc;
      logic [7:0] seen;
      for (int i = 0; i < exp.len(); i++) begin
         wait_cyc = 0;
         do begin
            @(negedge sys_clk);
            wait_cyc++;
         end while (got !== 1'b1 && wait_cyc < 200);
         seen = (got === 1'b1) ? got_byte : 8'hxx;
         num_checks++;
         if (seen !== exp[i]) begin
            fails++;
            $display("BAD %s byte %0d expected %h seen %h", what, i, exp[i], seen);
         end
      end
   endtask

   function automatic string wave(input string kw, input int n, input int v);
      string s;
      s = $sformatf("%s %0d%s", kw, n, CRLF);
      for (int i = 0; i < n; i++) s = {s, $sformatf("%0d%s", v, CRLF)};
      return {s, "\n"};
   endfunction

   task automatic t_state();
      string names [3] = '{"MENU", "MONITOR", "RUN"};
      wrm_op_t ops [3] = '{WRM_OP_MENU, WRM_OP_MONITOR, WRM_OP_RUN};
      for (int i = 0; i < 3; i++) begin
         @(negedge sys_clk) op_state = ops[i];
         expect_msg("state change", {"STATE ", names[i], CRLF, "\n"});
      end
      pulse(7'h01);
      @(negedge sys_clk);
      check_bit("busy", 1'b1, busy);
      expect_msg("state read", {"STATE RUN", CRLF, "\n"});
   endtask

   task automatic t_counters();
      slow = 1'b1;
      cnt_high = 32'hFFFF_FFFF;
      cnt_low = 32'h0000_0007;
      cnt_good = 32'h0000_03E8;
      pulse(7'h02);
      expect_msg("counters", {"COUNTERS", CRLF, "TOTAL 0", CRLF, "HIGH 4294967295", CRLF,
         "LOW 7", CRLF, "GOOD 1000", CRLF, "\n"});
      slow = 1'b0;
   endtask

   task automatic t_alarm();
      string txt = "OVERHEAT";
      for (int i = 0; i < txt.len(); i++) alarm_text[i*8 +: 8] = txt[i];
      alarm_len = 6'h08;
      pulse(7'h08);
      expect_msg("alarm event", {"ALARM OVERHEAT", CRLF, "\n"});
      alarm_len = 6'h00;
      pulse(7'h04);
      expect_msg("alarm read", {"ALARM ", CRLF, "\n"});
   endtask

   // Three whole 40 us periods plus a part period; all three reads pending at once
   task automatic t_wave();
      cur_amps = 16'h007B;
      volt_mv = 16'h11D7;
      @(negedge sys_clk) weld_active = 1'b1;
      repeat (1250) @(negedge sys_clk);
      weld_active = 1'b0;
      repeat (4) @(negedge sys_clk);
      pulse(7'h70);
      expect_msg("current", wave("CURRENT", 3, 123));
      expect_msg("voltage", wave("VOLTAGE", 3, 4567));
      expect_msg("power", wave("POWER", 3, 561));
      repeat (4) @(negedge sys_clk);
      check_bit("busy", 1'b0, busy);
      check_bit("tx_valid", 1'b0, tx_valid);
   endtask

   task automatic end_of_test();
      if (fails == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(negedge sys_clk);
      rstn = 1'b1;
      check_bit("idle busy", 1'b0, busy);
      t_state();
      t_counters();
      t_alarm();
      t_wave();
      end_of_test();
   end

   // Expected run is well under 10000 cycles
   initial begin
      #(5_000_000);
      fails++;
      end_of_test();
   end
endmodule // wrm_formatter_test

`default_nettype wire
